// ### src/frame_pkg.sv
// constants for the motion command frame handler
package frame_pkg;
  localparam int SERIAL_LEN = 9;
  localparam int BODY_LEN = 7;
  localparam int VALUE_LEN = 4;
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_CMD = 4'h1;
  localparam logic [3:0] IDX_TYPE = 4'h2;
  localparam logic [3:0] IDX_BANK = 4'h3;
  localparam logic [3:0] IDX_SUM = 4'h8;
  localparam logic [3:0] REPLY_IDX_STATUS = 4'h2;
  localparam int REPLY_BODY_LEN = 6;
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_STORED = 8'h65;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYPE = 8'h03;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;
  localparam logic [7:0] ST_LOCKED = 8'h05;
  localparam logic [7:0] ST_UNAVAIL = 8'h06;
endpackage : frame_pkg

// ### src/frame_checksum.sv
// running modulo-256 byte sum
`timescale 1ns/10ps
module frame_checksum (
  input wire logic clk, // clock
  input wire logic rst_b, // sync reset, active low
  input wire logic clear, // restart the sum
  input wire logic add, // add byte_in this cycle
  input wire logic [7:0] byte_in, // byte to add
  output logic [7:0] sum // current sum
);
  always_ff @(posedge clk) begin
    if (!rst_b || clear) begin
      sum <= 8'h00;
    end else if (add) begin
      sum <= sum + byte_in;
    end
  end
endmodule : frame_checksum

// ### src/motion_command_frame_handler.sv
// command frame receiver, executor handshake and reply sender
`timescale 1ns/10ps
// Notes on behaviour
// - body is command, type, bank, four value bytes
// - serial frame adds address and checksum bytes
// - address, cmd, type, bank, value MSB first, sum
// - checksum is byte sum of eight bytes
// - can mode: no address, no checksum
// - exactly one reply per accepted command
// - reply: host, module, status, cmd, value, sum
// - reply checksum is sum of reply bytes
// - can reply: no address, no checksum bytes
// - reply only after action completes, or at frame end for a bad checksum
// - never transmit without a received command
// - status 100 on successful execution
// - status 101 when stored to program
// - error statuses one through six
module motion_command_frame_handler
  import frame_pkg::*;
#(
  parameter int LEN_W = 4
) (
  input wire logic clk, // 50 MHz clock
  input wire logic rst_b, // sync reset, active low
  input wire logic can_mode, // high: frames carry no address or checksum
  input wire logic [7:0] module_addr, // own module address
  input wire logic [7:0] host_addr, // reply address for the host
  input wire logic rx_valid, // received byte strobe
  input wire logic [7:0] rx_data, // received byte
  input wire logic tx_ready, // link accepts tx byte
  output logic tx_valid, // reply byte is offered
  output logic [7:0] tx_data, // reply byte
  output logic tx_last, // last byte of reply
  output logic cmd_valid, // command handed to executor
  output logic [7:0] cmd_num, // command number
  output logic [7:0] cmd_type, // type byte
  output logic [7:0] cmd_bank, // motor or bank byte
  output logic [31:0] cmd_value, // value field
  input wire logic exec_done, // executor finished, pulse
  input wire logic [7:0] exec_status, // executor status code
  input wire logic [31:0] exec_value, // executor reply value
  output logic busy // high from frame end until reply sent
);
  import frame_pkg::*;

  typedef enum {RECEIVE, EXECUTE, REPLY} state_type;
  state_type state;
  logic [LEN_W-1:0] rx_idx;
  logic [LEN_W-1:0] tx_idx;
  logic [7:0] rx_sum;
  logic [7:0] tx_sum;
  logic [7:0] status;
  logic [31:0] reply_value;
  logic [7:0] pos;
  logic [LEN_W-1:0] frame_end;
  logic rx_take;
  logic frame_done;
  logic sum_ok;
  logic addr_ok;
  logic [7:0] rx_address;
  logic tx_take;
  logic [LEN_W-1:0] reply_end;

  // position within a serial frame; can frames start at the command byte
  assign pos = can_mode ? 8'(rx_idx) + 8'(IDX_CMD) : 8'(rx_idx);
  assign frame_end = can_mode ? LEN_W'(BODY_LEN - 1) : LEN_W'(SERIAL_LEN - 1);
  assign rx_take = (state == RECEIVE) && rx_valid;
  assign frame_done = rx_take && (rx_idx == frame_end);
  assign sum_ok = can_mode || (rx_sum == rx_data);
  // can frames carry no address byte, so every can frame is ours
  assign addr_ok = can_mode || (rx_address == module_addr);
  assign tx_take = tx_valid && tx_ready;
  assign reply_end = can_mode ? LEN_W'(REPLY_BODY_LEN - 1) : LEN_W'(SERIAL_LEN - 1);

  frame_checksum rx_check (
    .clk(clk),
    .rst_b(rst_b),
    .clear(frame_done || state != RECEIVE),
    .add(rx_take),
    .byte_in(rx_data),
    .sum(rx_sum)
  );

  frame_checksum tx_check (
    .clk(clk),
    .rst_b(rst_b),
    .clear(state != REPLY),
    .add(tx_take),
    .byte_in(tx_data),
    .sum(tx_sum)
  );

  // byte capture in frame order, value most significant first
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_idx <= '0;
      rx_address <= 8'h00;
      cmd_num <= 8'h00;
      cmd_type <= 8'h00;
      cmd_bank <= 8'h00;
      cmd_value <= 32'h0000_0000;
    end else if (rx_take) begin
      rx_idx <= frame_done ? '0 : rx_idx + 1'b1;
      unique case (pos[3:0])
        IDX_ADDR: rx_address <= rx_data;
        IDX_CMD: cmd_num <= rx_data;
        IDX_TYPE: cmd_type <= rx_data;
        IDX_BANK: cmd_bank <= rx_data;
        IDX_SUM: ;
        default: cmd_value <= {cmd_value[23:0], rx_data};
      endcase
    end
  end

  // main sequence; a foreign address frame leaves us in receive
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= RECEIVE;
      cmd_valid <= 1'b0;
      status <= ST_OK;
      reply_value <= 32'h0000_0000;
      busy <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      unique case (state)
        RECEIVE: begin
          if (frame_done) begin
            if (!addr_ok) begin
              state <= RECEIVE;
            end else if (!sum_ok) begin
              status <= ST_BAD_SUM;
              reply_value <= 32'h0000_0000;
              state <= REPLY;
              busy <= 1'b1;
            end else begin
              cmd_valid <= 1'b1;
              state <= EXECUTE;
              busy <= 1'b1;
            end
          end
        end
        EXECUTE: begin
          if (exec_done) begin
            status <= exec_status;
            reply_value <= exec_value;
            state <= REPLY;
          end
        end
        REPLY: begin
          if (tx_take && tx_last) begin
            state <= RECEIVE;
            busy <= 1'b0;
          end
        end
      endcase
    end
  end

  function automatic logic [7:0] reply_byte(input logic [3:0] p, input logic [7:0] s);
    logic [7:0] b;
    b = 8'h00;
    unique case (p)
      4'h0: b = host_addr;
      4'h1: b = module_addr;
      4'h2: b = status;
      4'h3: b = cmd_num;
      4'h4: b = reply_value[31:24];
      4'h5: b = reply_value[23:16];
      4'h6: b = reply_value[15:8];
      4'h7: b = reply_value[7:0];
      default: b = s;
    endcase
    return b;
  endfunction : reply_byte

  logic [3:0] tx_pos;
  logic [LEN_W-1:0] next_tx_idx;
  assign next_tx_idx = tx_idx + 1'b1;
  // can replies skip the two address bytes and the checksum
  assign tx_pos = can_mode ? 4'(next_tx_idx) + REPLY_IDX_STATUS : 4'(next_tx_idx);

  // transmit only while in reply state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_idx <= '0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else if (state == EXECUTE && exec_done) begin
      tx_idx <= '0;
      tx_valid <= 1'b1;
      tx_data <= can_mode ? exec_status : host_addr;
      tx_last <= 1'b0;
    end else if (state == RECEIVE && frame_done && !sum_ok && addr_ok) begin
      tx_idx <= '0;
      tx_valid <= 1'b1;
      tx_data <= host_addr;
      tx_last <= 1'b0;
    end else if (tx_take) begin
      if (tx_last) begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
        tx_idx <= '0;
      end else begin
        tx_idx <= next_tx_idx;
        tx_data <= reply_byte(tx_pos, tx_sum + tx_data);
        tx_last <= (next_tx_idx == reply_end);
      end
    end
  end

  sequence s_exec_end;
    state == EXECUTE && exec_done;
  endsequence

  property p_reply_after_done;
    @(posedge clk) disable iff (!rst_b)
      s_exec_end |=> tx_valid;
  endproperty
  a_reply_after_done: assert property (p_reply_after_done) else $error("no reply after done");

  property p_quiet_in_receive;
    @(posedge clk) disable iff (!rst_b)
      (state == RECEIVE && !busy) |-> !tx_valid;
  endproperty
  a_quiet_in_receive: assert property (p_quiet_in_receive) else $error("tx while idle");

  property p_foreign_dropped;
    @(posedge clk) disable iff (!rst_b)
      (frame_done && !can_mode && rx_address != module_addr) |=> !tx_valid && !cmd_valid;
  endproperty
  a_foreign_dropped: assert property (p_foreign_dropped) else $error("foreign frame answered");

  property p_bad_sum;
    @(posedge clk) disable iff (!rst_b)
      (frame_done && !can_mode && rx_address == module_addr && !sum_ok)
        |=> status == ST_BAD_SUM && !cmd_valid;
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("bad checksum not flagged");

  property p_cmd_once;
    @(posedge clk) disable iff (!rst_b)
      cmd_valid |=> !cmd_valid;
  endproperty
  a_cmd_once: assert property (p_cmd_once) else $error("command issued twice");

  property p_first_byte;
    @(posedge clk) disable iff (!rst_b)
      (state == EXECUTE && exec_done && !can_mode) |=> tx_data == host_addr;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("reply not led by host address");

  property p_status_copy;
    @(posedge clk) disable iff (!rst_b)
      s_exec_end |=> status == $past(exec_status);
  endproperty
  a_status_copy: assert property (p_status_copy) else $error("status not reported");

  property p_busy_end;
    @(posedge clk) disable iff (!rst_b)
      (tx_take && tx_last) |=> !busy && !tx_valid;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("reply did not end");
endmodule : motion_command_frame_handler

// ### dv/host_link_model.sv
// host end of the byte link: sends command frames, collects reply bytes
`timescale 1ns/10ps
module host_link_model (
  input wire logic clk, // clock
  input wire logic stall, // throttle reply acceptance
  input wire logic tx_valid, // reply byte offered
  input wire logic [7:0] tx_data, // reply byte
  input wire logic tx_last, // final reply byte flag
  output logic rx_valid, // command byte strobe
  output logic [7:0] rx_data, // command byte
  output logic tx_ready // reply byte accepted
);
  logic [7:0] got[$];
  int last_at = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // the bench only calls this once the previous reply is
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge clk);
      #1;
      rx_valid = 1'b1;
      rx_data = b[i];
    end
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    // idle line must not look like a repeat of the last byte
    rx_data = ~rx_data;
  endtask : send
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    if (tx_valid && tx_ready && tx_last) last_at = got.size();
    #1;
    tx_ready = stall ? ~tx_ready : 1'b1;
  end
endmodule : host_link_model

// ### dv/tb.sv
// self-checking bench for the command frame handler
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb;
  import frame_pkg::*;
  localparam logic [7:0] MOD = 8'h05;
  localparam logic [7:0] HOST = 8'h02;
  logic clk, rst_b, can_mode, stall, exec_done, tx_ready, tx_valid, tx_last;
  logic rx_valid, cmd_valid, busy;
  logic [7:0] rx_data, tx_data, cmd_num, cmd_type, cmd_bank, exec_status;
  logic [31:0] cmd_value, exec_value;
  logic [7:0] sts[6] = '{ST_BAD_CMD, ST_BAD_TYPE, ST_BAD_VALUE, ST_LOCKED, ST_UNAVAIL, ST_STORED};
  int n_fail = 0;
  int checked = 0;
  int n_cmd = 0;
  motion_command_frame_handler u_dut (.clk, .rst_b, .can_mode, .module_addr(MOD),
    .host_addr(HOST), .rx_valid, .rx_data, .tx_ready, .tx_valid, .tx_data, .tx_last,
    .cmd_valid, .cmd_num, .cmd_type, .cmd_bank, .cmd_value, .exec_done, .exec_status,
    .exec_value, .busy);
  host_link_model u_host (.clk, .stall, .tx_valid, .tx_data, .tx_last, .rx_valid, .rx_data,
    .tx_ready);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // executor stand-in: answers three cycles after each command
  always @(posedge clk) begin
    if (cmd_valid) begin
      n_cmd++;
      repeat (3) begin
        @(posedge clk);
        #1;
        `CHK("reply before done", 1'b0, tx_valid)
        `CHK("busy while executing", 1'b1, busy)
      end
      exec_done = 1'b1;
      @(posedge clk);
      #1;
      exec_done = 1'b0;
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic cmd(input logic cm, input logic [7:0] adr, c, input logic [31:0] v,
                     input logic [7:0] adj, st, input int n);
    logic [7:0] f[$];
    logic [7:0] e[$];
    logic [7:0] s;
    logic [31:0] ev;
    int k;
    k = n_cmd;
    can_mode = cm;
    exec_status = st;
    exec_value = ~v;
    f = {c, c + 8'h01, c + 8'h02, v[31:24], v[23:16], v[15:8], v[7:0]};
    if (!cm) begin
      f.push_front(adr);
      s = 8'h00;
      foreach (f[i]) s += f[i];
      f.push_back(s + adj);
    end
    u_host.got.delete();
    u_host.last_at = 0;
    u_host.send(f);
    for (int i = 0; i < 80 && u_host.got.size() < n; i++) @(posedge clk);
    repeat (6) @(posedge clk);
    #1;
    ev = (adj != 8'h00) ? 32'h0 : ~v;
    e = {(adj != 8'h00) ? ST_BAD_SUM : st, c, ev[31:24], ev[23:16], ev[15:8], ev[7:0]};
    if (!cm) begin
      e.push_front(MOD);
      e.push_front(HOST);
      s = 8'h00;
      foreach (e[i]) s += e[i];
      e.push_back(s);
    end
    `CHK("reply length", n, u_host.got.size())
    `CHK("last byte flag", n, u_host.last_at)
    `CHK("busy after reply", 1'b0, busy)
    `CHK("commands issued", k + ((n > 0 && adj == 8'h00) ? 1 : 0), n_cmd)
    if (n > 0) foreach (e[i]) `CHK("reply byte", e[i], u_host.got[i])
    if (n_cmd > k) begin
      `CHK("cmd value", v, cmd_value)
      `CHK("cmd bank", c + 8'h02, cmd_bank)
      `CHK("cmd type", c + 8'h01, cmd_type)
      `CHK("cmd num", c, cmd_num)
    end
    $display("test done: command %0h status %0h", c, st);
  endtask : cmd
  initial begin
    #100us;
    n_fail++;
    stop_test();
  end
  initial begin
    rst_b = 1'b0;
    can_mode = 1'b0;
    stall = 1'b0;
    exec_done = 1'b0;
    exec_status = 8'h00;
    exec_value = 32'h0;
    repeat (4) @(posedge clk);
    #1;
    rst_b = 1'b1;
    cmd(1'b0, MOD, 8'h04, 32'h8000_00FF, 8'h00, ST_OK, 9);
    cmd(1'b0, MOD, 8'h05, 32'h1234_5678, 8'h01, ST_OK, 9);
    cmd(1'b0, 8'h06, 8'h03, 32'h0, 8'h00, ST_OK, 0);
    stall = 1'b1;
    foreach (sts[i]) cmd(1'b0, MOD, 8'hF0 + 8'(i), 32'hFFFF_FFFF, 8'h00, sts[i], 9);
    stall = 1'b0;
    cmd(1'b1, 8'h00, 8'h8B, 32'h0102_0304, 8'h00, ST_OK, 6);
    stop_test();
  end
endmodule : tb
